//--- core/pump_protect_fault_supervisor.sv
// Pump-protect fault supervisor with AXI4-Lite registers
// Contract
// (R1) Two changeover relays driven by selectable functions
// (R2) Run input closed to 24 V means start
// (R3) Start request without alarm runs the motor
// (R4) Protect function assignable to either input
// (R5) Function code 7 selects pump protect
// (R6) Opened protect input starts the delay timer
// (R7) Alarm only after full delay; reclose cancels
// (R8) Expiry stops motor, raises alarm code 60
// (R9) Auto restart only when both settings allow
// (R10) Reset mode counts auto resets, default three
// (R11) Trip-lock alarms never cleared automatically
// (R12) Restart waits configured time, default 30 s
// (R13) External protect contacts should be normally closed
// (R14) One-second tick; reset clears timers and counters
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module pump_protect_fault_supervisor #(
    parameter int TICK_CYCLES = pump_protect_pkg::TICK_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        runCommandInput,
    input  wire logic        protectInputA,
    input  wire logic        protectInputB,
    input  wire logic        tripLockFault,
    output logic             motorRun,
    output logic             relay1No,
    output logic             relay1Nc,
    output logic             relay2No,
    output logic             relay2Nc,
    output logic             irq,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import pump_protect_pkg::*;

    function automatic logic isProtect(input logic [3:0] func);
        return func == FUNC_PROTECT; // R5
    endfunction : isProtect

    function automatic logic relayDrive(input logic [3:0] sel,
                                        input logic run,
                                        input logic alarm);
        unique case (sel)
            RLY_RUNNING: return run;
            RLY_ALARM:   return alarm;
            RLY_READY:   return !alarm;
            RLY_ON:      return 1'b1;
            default:     return 1'b0;
        endcase
    endfunction : relayDrive

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // ------------------------------------------------------------
    // Input synchronisers and filters
    // ------------------------------------------------------------
    logic [2:0]  syncRun_ff;
    logic [2:0]  syncA_ff;
    logic [2:0]  syncB_ff;
    logic        runFilt_ff;
    logic        filtA_ff;
    logic        filtB_ff;

    // Three stages per pin, accept level once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            syncRun_ff <= 3'h0;
            syncA_ff   <= 3'h7;
            syncB_ff   <= 3'h7;
            runFilt_ff <= 1'b0;
            filtA_ff   <= 1'b1;
            filtB_ff   <= 1'b1;
        end else begin
            syncRun_ff <= {syncRun_ff[1:0], runCommandInput};
            syncA_ff   <= {syncA_ff[1:0], protectInputA};
            syncB_ff   <= {syncB_ff[1:0], protectInputB};
            if (syncRun_ff[1] == syncRun_ff[2]) begin
                runFilt_ff <= syncRun_ff[2]; // R2
            end
            if (syncA_ff[1] == syncA_ff[2]) begin
                filtA_ff <= syncA_ff[2]; // R13
            end
            if (syncB_ff[1] == syncB_ff[2]) begin
                filtB_ff <= syncB_ff[2];
            end
        end
    end

    // ------------------------------------------------------------
    // One-second tick
    // ------------------------------------------------------------
    logic [TICK_W-1:0] divCnt_ff;
    logic              tick_ff;

    // Divider from the system clock
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            divCnt_ff <= '0;
            tick_ff   <= 1'b0;
        end else if (divCnt_ff == TICK_W'(TICK_CYCLES - 1)) begin
            divCnt_ff <= '0;
            tick_ff   <= 1'b1; // R14
        end else begin
            divCnt_ff <= divCnt_ff + 1'b1;
            tick_ff   <= 1'b0;
        end
    end

    tick_space_a: assert property (tick_ff |=> !tick_ff) // R14
        else $error("tick lasted more than one cycle");

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [3:0]  funcA_ff;
    logic [3:0]  funcB_ff;
    logic [15:0] protectDelay_ff;
    logic [3:0]  resetMode_ff;
    logic [15:0] restartTime_ff;
    logic [7:0]  relaySel_ff;
    logic [IRQ_W-1:0] irqMask_ff;
    logic        manualReset;
    logic        wrDo;
    logic [7:0]  wrAddr_ff;
    logic [31:0] wrData_ff;

    // Software writes to settings
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            funcA_ff        <= FUNC_NONE;
            funcB_ff        <= FUNC_NONE;
            protectDelay_ff <= DELAY_DEF;
            resetMode_ff    <= RSTMODE_DEF; // R10
            restartTime_ff  <= RSTTIME_DEF; // R12
            relaySel_ff     <= RELAY_DEF;
            irqMask_ff      <= '0;
        end else if (wrDo) begin
            unique case (wrAddr_ff)
                OFF_FUNC_A:   funcA_ff        <= wrData_ff[3:0]; // R4
                OFF_FUNC_B:   funcB_ff        <= wrData_ff[3:0]; // R4
                OFF_DELAY:    protectDelay_ff <= wrData_ff[15:0];
                OFF_RSTMODE:  resetMode_ff    <= wrData_ff[3:0];
                OFF_RSTTIME:  restartTime_ff  <= wrData_ff[15:0];
                OFF_RELAY:    relaySel_ff     <= wrData_ff[7:0];
                OFF_IRQ_MASK: irqMask_ff      <= wrData_ff[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    assign manualReset = wrDo && wrAddr_ff == OFF_CTRL && wrData_ff[0];

    // ------------------------------------------------------------
    // Protect delay timers
    // ------------------------------------------------------------
    sup_state_t  state_ff;
    logic [15:0] delayCntA_ff;
    logic [15:0] delayCntB_ff;
    logic        armA;
    logic        armB;
    logic        faultA;
    logic        faultB;

    assign armA   = isProtect(funcA_ff) && !filtA_ff && state_ff == ST_NORMAL;
    assign armB   = isProtect(funcB_ff) && !filtB_ff && state_ff == ST_NORMAL;
    assign faultA = armA && delayCntA_ff >= protectDelay_ff; // R7
    assign faultB = armB && delayCntB_ff >= protectDelay_ff; // R7

    // Count seconds while open, clear on reclose or alarm
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            delayCntA_ff <= '0;
            delayCntB_ff <= '0;
        end else begin
            if (!armA) begin
                delayCntA_ff <= '0; // R7
            end else if (tick_ff && !faultA) begin
                delayCntA_ff <= delayCntA_ff + 1'b1; // R6
            end
            if (!armB) begin
                delayCntB_ff <= '0; // R7
            end else if (tick_ff && !faultB) begin
                delayCntB_ff <= delayCntB_ff + 1'b1; // R6
            end
        end
    end

    cancel_a: assert property (filtA_ff |=> delayCntA_ff == '0) // R7
        else $error("delay timer not cancelled on reclose");
    fault_delay_a: assert property ( // R7
        faultA |-> $past(armA, 1) || protectDelay_ff == '0)
        else $error("alarm raised without full delay");

    // ------------------------------------------------------------
    // Alarm and restart supervisor
    // ------------------------------------------------------------
    logic [15:0] restartCnt_ff;
    logic [3:0]  autoCnt_ff;
    logic [7:0]  alarmCode_ff;
    logic        tripLock_ff;
    logic        protectFault;
    logic        autoAllowed;
    logic        restartNow;

    assign protectFault = faultA || faultB;
    assign autoAllowed  = resetMode_ff != RSTMODE_MANUAL
                       && restartTime_ff != '0
                       && autoCnt_ff < resetMode_ff; // R9 R10
    assign restartNow   = state_ff == ST_ALARMED && !tripLock_ff
                       && restartCnt_ff >= restartTime_ff; // R12

    // State, alarm code and auto-reset count
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_ff     <= ST_NORMAL; // R14
            alarmCode_ff <= ALARM_NONE;
            autoCnt_ff   <= '0;
            tripLock_ff  <= 1'b0;
        end else if (tripLockFault) begin
            state_ff     <= ST_LOCKOUT; // R11
            alarmCode_ff <= ALARM_TRIPLOCK;
            tripLock_ff  <= 1'b1;
        end else if (manualReset) begin
            state_ff     <= ST_NORMAL;
            alarmCode_ff <= ALARM_NONE;
            autoCnt_ff   <= '0;
            tripLock_ff  <= 1'b0;
        end else begin
            unique case (state_ff)
                ST_NORMAL: begin
                    if (protectFault) begin
                        alarmCode_ff <= ALARM_PROTECT; // R8
                        state_ff <= autoAllowed ? ST_ALARMED
                                                : ST_LOCKOUT; // R9
                    end
                end
                ST_ALARMED: begin
                    if (restartNow) begin
                        state_ff     <= ST_NORMAL;
                        alarmCode_ff <= ALARM_NONE;
                        autoCnt_ff   <= autoCnt_ff + 1'b1; // R10
                    end
                end
                ST_LOCKOUT: ;
            endcase
        end
    end

    // Restart wait counter
    always_ff @(posedge sys_clk) begin
        if (srst || state_ff != ST_ALARMED) begin
            restartCnt_ff <= '0; // R14
        end else if (tick_ff && !restartNow) begin
            restartCnt_ff <= restartCnt_ff + 1'b1; // R12
        end
    end

    alarm_code_a: assert property ( // R8
        $rose(state_ff != ST_NORMAL) && !$past(tripLockFault, 1)
        |-> alarmCode_ff == ALARM_PROTECT)
        else $error("protect alarm code not 60");
    restart_gate_a: assert property ( // R10
        state_ff == ST_NORMAL && protectFault && !tripLockFault
        && !manualReset && resetMode_ff == RSTMODE_MANUAL
        |=> state_ff == ST_LOCKOUT)
        else $error("manual reset mode restarted");
    restart_wait_a: assert property ( // R12
        state_ff == ST_ALARMED ##1 state_ff == ST_NORMAL && !$past(manualReset)
        |-> $past(restartCnt_ff) >= $past(restartTime_ff))
        else $error("restart before wait elapsed");
    lock_hold_a: assert property (
        tripLock_ff && !manualReset |=> state_ff == ST_LOCKOUT) // R11
        else $error("trip lock cleared automatically");

    // ------------------------------------------------------------
    // Motor and relay outputs
    // ------------------------------------------------------------
    logic alarmOn;
    logic rly1;
    logic rly2;

    assign alarmOn  = state_ff != ST_NORMAL;
    assign motorRun = runFilt_ff && !alarmOn; // R3
    assign rly1     = relayDrive(relaySel_ff[3:0], motorRun, alarmOn); // R1
    assign rly2     = relayDrive(relaySel_ff[7:4], motorRun, alarmOn); // R1

    // Changeover contacts
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            relay1No <= 1'b0;
            relay1Nc <= 1'b1;
            relay2No <= 1'b0;
            relay2Nc <= 1'b1;
        end else begin
            relay1No <= rly1;
            relay1Nc <= !rly1;
            relay2No <= rly2;
            relay2Nc <= !rly2;
        end
    end

    motor_gate_a: assert property ( // R3
        alarmOn |-> !motorRun
                    ##1 (!relay1No || relaySel_ff[3:0] != RLY_RUNNING))
        else $error("motor runs during alarm");
    relay_pair_a: assert property ( // R1
        relay1No != relay1Nc && relay2No != relay2Nc)
        else $error("relay contacts not complementary");

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    logic [IRQ_W-1:0] irqStat_ff;
    logic [IRQ_W-1:0] irqEvt;
    logic             statRead;

    assign irqEvt[IRQ_ALARM]   = state_ff == ST_NORMAL && protectFault;
    assign irqEvt[IRQ_RESTART] = restartNow;
    assign irqEvt[IRQ_LOCKOUT] = state_ff != ST_LOCKOUT
                              && (tripLockFault
                                  || (irqEvt[IRQ_ALARM] && !autoAllowed));

    // Sticky bits, read clears, new event wins
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irqStat_ff <= '0;
        end else begin
            irqStat_ff <= (statRead ? '0 : irqStat_ff) | irqEvt;
        end
    end

    assign irq = |(irqStat_ff & irqMask_ff);

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic awHeld_ff;
    logic wHeld_ff;
    logic bValid_ff;
    logic [1:0] bResp_ff;

    assign s_axi_awready = !awHeld_ff && !bValid_ff;
    assign s_axi_wready  = !wHeld_ff && !bValid_ff;
    assign wrDo          = awHeld_ff && wHeld_ff && !bValid_ff;
    assign s_axi_bvalid  = bValid_ff;
    assign s_axi_bresp   = bResp_ff;

    // Capture address and data in either order, then answer
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            bValid_ff <= 1'b0;
            bResp_ff  <= RESP_OKAY;
            wrAddr_ff <= '0;
            wrData_ff <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_ff <= 1'b1;
                wrAddr_ff <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_ff  <= 1'b1;
                wrData_ff <= s_axi_wdata;
            end
            if (wrDo) begin
                awHeld_ff <= 1'b0;
                wHeld_ff  <= 1'b0;
                bValid_ff <= 1'b1;
                bResp_ff  <= (wrAddr_ff <= OFF_IRQ_MASK
                              && wrAddr_ff != OFF_STATUS)
                             ? RESP_OKAY : RESP_SLVERR;
            end else if (bValid_ff && s_axi_bready) begin
                bValid_ff <= 1'b0;
            end
        end
    end

    logic [7:0] rdAddr;
    logic [31:0] rdMux;
    logic [1:0] rdResp;

    assign rdAddr        = {s_axi_araddr[7:2], 2'h0};
    assign s_axi_arready = !s_axi_rvalid;
    assign statRead      = s_axi_arvalid && s_axi_arready
                        && rdAddr == OFF_IRQ_STAT;

    // Read data selection
    always_comb begin
        rdMux  = '0;
        rdResp = RESP_OKAY;
        unique case (rdAddr)
            OFF_FUNC_A:   rdMux[3:0]  = funcA_ff;
            OFF_FUNC_B:   rdMux[3:0]  = funcB_ff;
            OFF_DELAY:    rdMux[15:0] = protectDelay_ff;
            OFF_RSTMODE:  rdMux[3:0]  = resetMode_ff;
            OFF_RSTTIME:  rdMux[15:0] = restartTime_ff;
            OFF_RELAY:    rdMux[7:0]  = relaySel_ff;
            OFF_STATUS:   rdMux[19:0] = {autoCnt_ff, alarmCode_ff, 5'h0,
                                         tripLock_ff, alarmOn, motorRun};
            OFF_CTRL:     rdMux       = '0;
            OFF_IRQ_STAT: rdMux[IRQ_W-1:0] = irqStat_ff;
            OFF_IRQ_MASK: rdMux[IRQ_W-1:0] = irqMask_ff;
            default:      rdResp = RESP_SLVERR;
        endcase
    end

    // Registered read answer
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMux;
            s_axi_rresp  <= rdResp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : pump_protect_fault_supervisor

//--- pkg/pump_protect_pkg.sv
// Constants shared by the pump-protect supervisor
package pump_protect_pkg;

    // ------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 10_000_000;
    localparam int TICK_PERIOD_S = 1;
    localparam int TICK_CYCLES   = CLK_HZ * TICK_PERIOD_S;
    localparam int TICK_W        = 24;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_FUNC_A   = 8'h00;
    localparam logic [7:0] OFF_FUNC_B   = 8'h04;
    localparam logic [7:0] OFF_DELAY    = 8'h08;
    localparam logic [7:0] OFF_RSTMODE  = 8'h0c;
    localparam logic [7:0] OFF_RSTTIME  = 8'h10;
    localparam logic [7:0] OFF_RELAY    = 8'h14;
    localparam logic [7:0] OFF_STATUS   = 8'h18;
    localparam logic [7:0] OFF_CTRL     = 8'h1c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h24;

    // ------------------------------------------------------------
    // Field values and reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  FUNC_PROTECT    = 4'h7;
    localparam logic [3:0]  FUNC_NONE       = 4'h0;
    localparam logic [15:0] DELAY_DEF       = 16'h000a;
    localparam logic [3:0]  RSTMODE_MANUAL  = 4'h0;
    localparam logic [3:0]  RSTMODE_DEF     = 4'h3;
    localparam logic [15:0] RSTTIME_DEF     = 16'h001e;
    localparam logic [7:0]  ALARM_PROTECT   = 8'h3c;
    localparam logic [7:0]  ALARM_TRIPLOCK  = 8'h01;
    localparam logic [7:0]  ALARM_NONE      = 8'h00;

    // Relay function selections
    localparam logic [3:0]  RLY_OFF     = 4'h0;
    localparam logic [3:0]  RLY_RUNNING = 4'h1;
    localparam logic [3:0]  RLY_ALARM   = 4'h2;
    localparam logic [3:0]  RLY_READY   = 4'h3;
    localparam logic [3:0]  RLY_ON      = 4'h4;
    localparam logic [7:0]  RELAY_DEF   = 8'h21;

    // Interrupt bits
    localparam int IRQ_W       = 3;
    localparam int IRQ_ALARM   = 0;
    localparam int IRQ_RESTART = 1;
    localparam int IRQ_LOCKOUT = 2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_ALARMED,
        ST_LOCKOUT
    } sup_state_t;

endpackage : pump_protect_pkg

//--- test/ext_contacts_model.sv
// Model of the external protect switches and the start contact
`timescale 1ns/1ps
module ext_contacts_model (
    input  wire logic runClosed,
    input  wire logic openA,
    input  wire logic openB,
    output logic      runCommandInput,
    output logic      protectInputA,
    output logic      protectInputB
);
    // Closed start contact ties the pin to 24 V, read as high
    assign runCommandInput = runClosed;
    // Normally closed switches: a fault or broken wire reads low
    assign protectInputA = !openA;
    assign protectInputB = !openB;
endmodule : ext_contacts_model

//--- test/pump_protect_fault_supervisor_tb_top.sv
// Self-checking bench for the pump-protect fault supervisor
`timescale 1ns/1ps
module pump_protect_fault_supervisor_tb_top;
    import pump_protect_pkg::*;
    localparam int TK = 10;
    localparam int LIMIT = 5000;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        runClosed = 1'b0;
    logic        openA = 1'b0;
    logic        openB = 1'b0;
    logic        tripLockFault = 1'b0;
    logic        runCommandInput, protectInputA, protectInputB, motorRun;
    logic        relay1No, relay1Nc, relay2No, relay2Nc, irq;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [31:0] d;
    logic [15:0] lf = 16'h005d;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;
    // Reset values of the writable registers
    logic [7:0]  ra[7] = '{OFF_FUNC_A, OFF_FUNC_B, OFF_DELAY, OFF_RSTMODE,
                           OFF_RSTTIME, OFF_RELAY, OFF_IRQ_MASK};
    int          rv[7] = '{0, 0, 10, 3, 30, 'h21, 0};

    always #50 sys_clk = !sys_clk;

    ext_contacts_model u_ext (.runClosed, .openA, .openB, .runCommandInput,
                              .protectInputA, .protectInputB);
    pump_protect_fault_supervisor #(.TICK_CYCLES(TK)) u_dut (
        .sys_clk, .srst, .runCommandInput, .protectInputA, .protectInputB,
        .tripLockFault, .motorRun, .relay1No, .relay1Nc, .relay2No,
        .relay2Nc, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chkPin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkPin

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bit aw = 0;
        bit w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    // Expected status word from the given flags, code and count; code checked only when alarmed
    task automatic chkSt(input logic m, al, tr, input logic [7:0] cd,
                         input logic [3:0] cn);
        logic [31:0] mk;
        mk = al ? 32'h000fff07 : 32'h000f0007;
        rd(OFF_STATUS);
        chk(d & mk, {12'h0, cn, cd, 5'h0, tr, al, m} & mk);
    endtask : chkSt

    task automatic secs(input int n);
        repeat (n * TK) @(posedge sys_clk);
    endtask : secs

    task test_done;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        for (int i = 0; i < 7; i++) begin
            rd(ra[i]);
            chk(d, rv[i]);
        end
        rd(8'h28);
        chk(resp, RESP_SLVERR);
        wr(OFF_STATUS, 32'h1);
        chk(resp, RESP_SLVERR);
        lf = lfsr(lf);
        wr(OFF_RSTTIME, {16'h0, lf});
        rd(OFF_RSTTIME);
        chk(d, {16'h0, lf});
        $display("register test done");
        runClosed <= 1'b1;
        secs(1);
        chkPin(motorRun, 1'b1);
        chkPin(relay1No, 1'b1);
        chkPin(relay1Nc, 1'b0);
        chkPin(relay2No, 1'b0);
        wr(OFF_RELAY, 32'h40);
        secs(1);
        chkPin(relay1No, 1'b0);
        chkPin(relay2No, 1'b1);
        chkPin(relay2Nc, 1'b0);
        wr(OFF_RELAY, 32'h21);
        $display("run test done");
        wr(OFF_FUNC_A, FUNC_PROTECT);
        wr(OFF_FUNC_B, FUNC_PROTECT);
        wr(OFF_DELAY, 32'h3);
        wr(OFF_RSTMODE, 32'h1);
        wr(OFF_RSTTIME, 32'h5);
        wr(OFF_IRQ_MASK, 32'h6);
        openA <= 1'b1;
        secs(1);
        openA <= 1'b0;
        secs(1);
        chkSt(1'b1, 1'b0, 1'b0, ALARM_NONE, 4'h0);
        openA <= 1'b1;
        secs(5);
        chkSt(1'b0, 1'b1, 1'b0, ALARM_PROTECT, 4'h0);
        chkPin(motorRun, 1'b0);
        chkPin(relay2No, 1'b1);
        chkPin(irq, 1'b0);
        openA <= 1'b0;
        wr(OFF_IRQ_MASK, 32'h7);
        chkPin(irq, 1'b1);
        rd(OFF_IRQ_STAT);
        chk(d, 32'h1);
        @(posedge sys_clk);
        chkPin(irq, 1'b0);
        secs(7);
        chkSt(1'b1, 1'b0, 1'b0, ALARM_NONE, 4'h1);
        rd(OFF_IRQ_STAT);
        chk(d, 32'h2);
        $display("protect test done");
        openB <= 1'b1;
        secs(5);
        chkSt(1'b0, 1'b1, 1'b0, ALARM_PROTECT, 4'h1);
        openB <= 1'b0;
        secs(8);
        chkSt(1'b0, 1'b1, 1'b0, ALARM_PROTECT, 4'h1);
        rd(OFF_IRQ_STAT);
        chk(d, 32'h5);
        wr(OFF_CTRL, 32'h1);
        secs(1);
        chkSt(1'b1, 1'b0, 1'b0, ALARM_NONE, 4'h0);
        $display("lockout test done");
        wr(OFF_RSTMODE, 32'h3);
        tripLockFault <= 1'b1;
        @(posedge sys_clk);
        tripLockFault <= 1'b0;
        secs(7);
        chkSt(1'b0, 1'b1, 1'b1, ALARM_TRIPLOCK, 4'h0);
        srst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        secs(1);
        chkSt(1'b1, 1'b0, 1'b0, ALARM_NONE, 4'h0);
        rd(OFF_DELAY);
        chk(d, 32'ha);
        $display("trip lock test done");
        wr(OFF_FUNC_B, FUNC_PROTECT);
        wr(OFF_RSTMODE, RSTMODE_MANUAL);
        openB <= 1'b1;
        secs(12);
        chkSt(1'b0, 1'b1, 1'b0, ALARM_PROTECT, 4'h0);
        rd(OFF_IRQ_STAT);
        chk(d, 32'h5);
        $display("manual mode test done");
        test_done();
    end
endmodule : pump_protect_fault_supervisor_tb_top
